/* File: bgdc_chk_asserts.sv */
// Concurrent checks on the ports of the bitmap display block.
// Assumes the block runs as sync master from one clock.
`timescale 1ns/1ps
module bgdc_chk
  import bgdc_pkg::*;
#(
  parameter int          LINE_CYC = LINE_CYC_DF,
  parameter int          HS_CYC   = HS_CYC_DF,
  parameter int          VS_CYC   = VS_CYC_DF,
  parameter logic [18:0] BASE_HI  = BASE_HI_DF
) (
  // Clock, reset and bus.
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hready,
  input logic                  hreadyout,
  input logic                  hresp,
  input bgdc_pkg::bgdc_straps_s straps,
  // Video and sync.
  input logic                  hres_o,
  input logic                  blank_o,
  input logic                  hsync_o,
  input logic                  vsync_o
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  int   hs_len;
  int   vs_len;
  int   ln_len;
  logic seen;
  wire logic req = hsel && hready && htrans[1];
  wire logic hit = haddr[31:5] == {BASE_HI, straps.base};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_len <= 0;
      vs_len <= 0;
      ln_len <= 0;
      seen   <= 1'b0;
    end else begin
      hs_len <= hsync_o ? hs_len + 1 : 0;
      vs_len <= vsync_o ? vs_len + 1 : 0;
      ln_len <= $rose(hsync_o) ? 1 : ln_len + 1;
      seen   <= seen | $rose(hsync_o);
    end
  end
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_reg_ack; req && haddr[4:0] != REG_DATA |=> hreadyout; endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("register access stalled");
  property p_dot_stall; req && hit && haddr[4:0] == REG_DATA |=> !hreadyout [*2]; endproperty
  a_dot_stall: assert property (p_dot_stall) else $error("dot reply too early");
  property p_hs_width; $fell(hsync_o) |-> hs_len == HS_CYC; endproperty
  a_hs_width: assert property (p_hs_width) else $error("hsync width wrong");
  property p_line; $rose(hsync_o) && seen |-> ln_len == LINE_CYC; endproperty
  a_line: assert property (p_line) else $error("line period wrong");
  property p_vs_width; $fell(vsync_o) |-> vs_len == VS_CYC; endproperty
  a_vs_width: assert property (p_vs_width) else $error("vsync width wrong");
  property p_blank; hsync_o |-> blank_o; endproperty
  a_blank: assert property (p_blank) else $error("sync not blanked");
  property p_hres; hres_o |=> !hres_o; endproperty
  a_hres: assert property (p_hres) else $error("line reset pulse too long");
endmodule
bind bgdc_top bgdc_chk #(.LINE_CYC(LINE_CYC), .HS_CYC(HS_CYC), .VS_CYC(VS_CYC),
  .BASE_HI(BASE_HI)) bgdc_chk_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .straps(straps), .hres_o(hres_o), .blank_o(blank_o), .hsync_o(hsync_o),
  .vsync_o(vsync_o));

/* File: bgdc_host.sv */
// Host model issuing single word AHB-Lite transfers.
// Assumes hready is the block's hreadyout and every reply is OKAY.
`timescale 1ns/1ps
module bgdc_host (
  // Clock and reply.
  input wire logic        clock,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  // Request.
  output logic            hsel,
  output logic [31:0]     haddr,
  output logic [1:0]      htrans,
  output logic            hwrite,
  output logic [2:0]      hsize,
  output logic [31:0]     hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output int n);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* File: bgdc_mem.sv */
// Refresh memory of one bit per screen point, single port.
// Assumes the caller arbitrates so that at most one access comes per cycle.
`timescale 1ns/1ps
module bgdc_mem #(
  parameter int AW = 18
) (
  // Clock.
  input  wire logic          clock,
  // Access port.
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic          wdata,
  output logic               rdata_q
);

  logic mem_q [2**AW];

  always_ff @(posedge clock) begin
    if (en) begin
      if (we) begin
        mem_q[addr] <= wdata;
      end
      rdata_q <= mem_q[addr];
    end
  end

endmodule

/* File: bgdc_pkg.sv */
// Shared constants, carrier types and helpers of the bitmap display block.
// Assumes one 100 MHz clock; the cycle counts and dot dividers below are derived from that rate.
package bgdc_pkg;

  // ----------------------------------------
  // Clock and video timing
  // ----------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int LINE_HZ     = 15_800;
  localparam int ACT_NS      = 46_000;
  localparam int HS_NS       = 5_670;
  localparam int VS_NS       = 190_000;
  localparam int LINE_CYC_DF = CLK_HZ / LINE_HZ;
  localparam int ACT_CYC_DF  = ACT_NS / CLK_NS;
  localparam int HS_CYC_DF   = HS_NS / CLK_NS;
  localparam int VS_CYC_DF   = VS_NS / CLK_NS;
  localparam int DOT_FAST_HZ = 11_066_880;
  localparam int DOT_SLOW_HZ = 5_533_440;
  localparam logic [4:0] DIV_FAST = 5'(CLK_HZ / DOT_FAST_HZ);
  localparam logic [4:0] DIV_SLOW = 5'(CLK_HZ / DOT_SLOW_HZ);

  // ----------------------------------------
  // Raster geometry: totals and sync points in half lines, display height in lines, blank limits in dots
  // ----------------------------------------
  localparam logic [9:0]  HALF_TOT_60 = 10'h20d;
  localparam logic [9:0]  HALF_TOT_50 = 10'h271;
  localparam logic [8:0]  VDISP_60    = 9'h0f0;
  localparam logic [8:0]  VDISP_50    = 9'h100;
  localparam logic [9:0]  VS_HALF_60  = 10'h1e8;
  localparam logic [9:0]  VS_HALF_50  = 10'h228;
  localparam logic [10:0] HRES_256    = 11'h100;
  localparam logic [10:0] HRES_512    = 11'h200;
  localparam logic [10:0] HRES_1024   = 11'h400;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [4:0] REG_X      = 5'h00;
  localparam logic [4:0] REG_Y      = 5'h04;
  localparam logic [4:0] REG_SCROLL = 5'h08;
  localparam logic [4:0] REG_DATA   = 5'h0c;
  localparam logic [4:0] REG_CTRL   = 5'h10;
  localparam logic [4:0] REG_STAT   = 5'h14;
  localparam int ERASE_BIT  = 16;
  localparam int CTRL_VIDEO = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [18:0] BASE_HI_DF = 19'h00000;
  localparam logic [1:0] RAM_W_4K  = 2'h1;
  localparam logic [1:0] RAM_W_8K  = 2'h2;
  localparam logic [1:0] RAM_W_16K = 2'h3;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] base;
    logic       master;
    logic [3:0] img_bit;
    logic [1:0] ram;
    logic       pal;
    logic       blank512;
    logic       fast_dot;
    logic       v512;
    logic       h1024;
    logic [1:0] fmt;
  } bgdc_straps_s;

  typedef struct packed {
    logic        dot_en;
    logic        frame_end;
    logic        hblank;
    logic        vblank;
    logic        hsync;
    logic        vsync;
    logic        field;
    logic [8:0]  line;
    logic [10:0] dot_idx;
  } bgdc_tim_s;

  typedef enum logic [3:0] {
    DS_IDLE = 4'h1,
    DS_REQ  = 4'h2,
    DS_HOLD = 4'h4,
    DS_DONE = 4'h8
  } bgdc_dot_e;

  // Maps a dot coordinate to a memory bit address for the strapped format.
  function automatic logic [17:0] dot_addr(input logic [1:0] fmt,
                                           input logic [9:0] x,
                                           input logic [8:0] y);
    case (fmt)
      2'h0: dot_addr = {2'h0, y[7:0], x[7:0]};
      2'h1: dot_addr = {1'b0, y[7:0], x[8:0]};
      2'h2: dot_addr = {y[8:0], x[8:0]};
      default: dot_addr = {y[7:0], x[9:0]};
    endcase
  endfunction

  // Access hold time in cycles for the populated RAM size.
  function automatic logic [1:0] ram_wait(input logic [1:0] ram);
    case (ram)
      2'h0: ram_wait = RAM_W_4K;
      2'h1: ram_wait = RAM_W_8K;
      default: ram_wait = RAM_W_16K;
    endcase
  endfunction

endpackage

/* File: bgdc_timing.sv */
// Line, field and dot timing with master or slave sync.
// Assumes the external sync inputs are already synchronised to clock.
`timescale 1ns/1ps
module bgdc_timing
  import bgdc_pkg::*;
#(
  parameter int LINE_CYC = LINE_CYC_DF,
  parameter int ACT_CYC  = ACT_CYC_DF,
  parameter int HS_CYC   = HS_CYC_DF,
  parameter int VS_CYC   = VS_CYC_DF
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst,
  // Straps and external sync.
  input  bgdc_pkg::bgdc_straps_s cfg,
  input  wire logic             ext_dot,
  input  wire logic             ext_hres,
  input  wire logic             ext_vres,
  // Timing to the core.
  output bgdc_pkg::bgdc_tim_s   tim,
  // Sync pins driven as master.
  output logic                  dot_q,
  output logic                  hres_q,
  output logic                  vres_q,
  output logic                  sync_oe
);

  localparam int HW = $clog2(LINE_CYC);
  localparam int VW = $clog2(VS_CYC + 1);

  logic [HW-1:0] h_q;
  logic [9:0]    vh_q;
  logic [4:0]    dv_q;
  logic [10:0]   idx_q;
  logic [VW-1:0] vs_q;
  logic [2:0]    e_q;
  logic          field_q;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire [4:0]  div      = cfg.fast_dot ? DIV_FAST : DIV_SLOW;
  wire        dv_end   = dv_q == div - 5'h01;
  wire        h_last   = h_q == HW'(LINE_CYC - 1);
  wire        h_half   = h_q == HW'(LINE_CYC / 2 - 1);
  wire [9:0]  vtot     = cfg.pal ? HALF_TOT_50 : HALF_TOT_60;
  wire [9:0]  vs_at    = cfg.pal ? VS_HALF_50 : VS_HALF_60;
  wire [8:0]  vdisp    = cfg.pal ? VDISP_50 : VDISP_60;
  wire        step     = h_last | h_half;
  wire        dot_en   = cfg.master ? dv_end : ext_dot & ~e_q[0];
  wire        line_end = cfg.master ? h_last : ext_hres & ~e_q[1];
  wire        frm_end  = cfg.master ? step & (vh_q == vtot - 10'h001)
                                    : ext_vres & ~e_q[2];
  wire [10:0] blim     = ~cfg.blank512 ? HRES_256 :
                         cfg.h1024 ? HRES_1024 : HRES_512;
  wire        h_act    = h_q < HW'(ACT_CYC);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      h_q <= '0;
      vh_q <= 10'h000;
      dv_q <= 5'h00;
      idx_q <= 11'h000;
      vs_q <= '0;
      e_q <= 3'h0;
      field_q <= 1'b0;
    end else begin
      e_q <= {ext_vres, ext_hres, ext_dot};
      dv_q <= dv_end ? 5'h00 : dv_q + 5'h01;
      h_q <= line_end ? '0 : h_q + HW'(1);
      if (frm_end) begin
        vh_q <= 10'h000;
        field_q <= ~field_q;
      end else if (step) begin
        vh_q <= vh_q + 10'h001;
      end
      if (line_end) begin
        idx_q <= 11'h000;
      end else if (dot_en && h_act && !idx_q[10]) begin
        idx_q <= idx_q + 11'h001;
      end
      if (step && vh_q == vs_at) begin
        vs_q <= VW'(VS_CYC);
      end else if (vs_q != '0) begin
        vs_q <= vs_q - VW'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dot_q <= 1'b0;
      hres_q <= 1'b0;
      vres_q <= 1'b0;
    end else begin
      dot_q <= dv_q < {1'b0, div[4:1]};
      hres_q <= line_end;
      vres_q <= frm_end;
    end
  end

  assign sync_oe = cfg.master;
  assign tim.dot_en = dot_en;
  assign tim.frame_end = frm_end;
  assign tim.hblank = ~h_act | (idx_q >= blim);
  assign tim.hsync = h_q >= HW'(LINE_CYC - HS_CYC);
  assign tim.vblank = vh_q[9:1] >= vdisp;
  assign tim.vsync = vs_q != '0;
  assign tim.field = field_q;
  assign tim.line = vh_q[9:1];
  assign tim.dot_idx = idx_q;

endmodule

/* File: bgdc_top.sv */
// Bitmap graphics display controller with an AHB-Lite register slave.
// Assumes straps and sync pins are asynchronous and a single AHB master.
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module bgdc_top
  import bgdc_pkg::*;
#(
  parameter int          LINE_CYC = LINE_CYC_DF,
  parameter int          ACT_CYC  = ACT_CYC_DF,
  parameter int          HS_CYC   = HS_CYC_DF,
  parameter int          VS_CYC   = VS_CYC_DF,
  parameter logic [18:0] BASE_HI  = BASE_HI_DF
) (
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          rst,
  // AHB-Lite slave.
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Configuration straps.
  input  bgdc_pkg::bgdc_straps_s straps,
  // Sync pins, two-way.
  input  wire logic          dot_i,
  output logic               dot_o,
  output logic               dot_oe,
  input  wire logic          hres_i,
  output logic               hres_o,
  output logic               hres_oe,
  input  wire logic          vres_i,
  output logic               vres_o,
  output logic               vres_oe,
  // Video.
  input  wire logic          alpha_i,
  output logic               video_o,
  output logic               blank_o,
  output logic               hsync_o,
  output logic               vsync_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (LINE_CYC <= ACT_CYC + HS_CYC || VS_CYC < 1 || HS_CYC < 1) begin : g_chk
    $error("bgdc_top: line timing parameters do not fit");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int SW = $bits(bgdc_straps_s) + 4;

  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {straps, alpha_i, vres_i, hres_i, dot_i};
      s2_q <= s1_q;
    end
  end

  bgdc_straps_s cfg;
  wire          ext_dot  = s2_q[0];
  wire          ext_hres = s2_q[1];
  wire          ext_vres = s2_q[2];
  wire          alpha    = s2_q[3];

  assign cfg = bgdc_straps_s'(s2_q[SW-1:4]);

  // ----------------------------------------
  // Timing generator
  // ----------------------------------------
  bgdc_tim_s tim;
  logic      sync_oe;

  bgdc_timing #(
    .LINE_CYC (LINE_CYC),
    .ACT_CYC  (ACT_CYC),
    .HS_CYC   (HS_CYC),
    .VS_CYC   (VS_CYC)
  ) u_timing (
    .clock    (clock),
    .rst      (rst),
    .cfg      (cfg),
    .ext_dot  (ext_dot),
    .ext_hres (ext_hres),
    .ext_vres (ext_vres),
    .tim      (tim),
    .dot_q    (dot_o),
    .hres_q   (hres_o),
    .vres_q   (vres_o),
    .sync_oe  (sync_oe)
  );

  assign dot_oe = sync_oe;
  assign hres_oe = sync_oe;
  assign vres_oe = sync_oe;

  // ----------------------------------------
  // Registers and bus state
  // ----------------------------------------
  logic [9:0]  x_q;
  logic [8:0]  y_q;
  logic [8:0]  scroll_q;
  logic [8:0]  scroll_act_q;
  logic [31:0] ctrl_q;
  logic        dp_q;
  logic        dp_wr_q;
  logic        dp_hit_q;
  logic [4:0]  dp_off_q;
  logic [31:0] hrdata_q;
  logic        er_busy_q;
  logic        er_val_q;
  logic [17:0] er_cnt_q;
  logic [1:0]  wt_q;
  logic        hg_q;
  logic        rg_q;
  logic        pix_q;
  logic        blank_d1_q;
  logic [3:0]  out_q;
  bgdc_dot_e   st_q;
  bgdc_dot_e   st_d;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Strapped base match.
  wire        hit    = haddr[31:5] == {BASE_HI, cfg.base};
  wire        acc    = hsel & hready & htrans[1];
  wire [4:0]  off    = haddr[4:0];
  wire        acc_dt = acc & hit & (off == REG_DATA);
  wire        dp_dot = dp_q & dp_hit_q & (dp_off_q == REG_DATA);
  wire        reg_wr = dp_q & dp_wr_q & dp_hit_q & ~dp_dot;
  wire [31:0] stat   = {28'h0, tim.field, tim.vblank, er_busy_q, 1'b0};
  wire [31:0] rd_reg = ~hit ? 32'h0 :
                       (off == REG_X) ? {22'h0, x_q} :
                       (off == REG_Y) ? {23'h0, y_q} :
                       (off == REG_SCROLL) ? {23'h0, scroll_q} :
                       (off == REG_CTRL) ? ctrl_q :
                       (off == REG_STAT) ? stat : 32'h0;
  wire        wr_bit = hwdata[cfg.img_bit];
  wire        wr_era = hwdata[ERASE_BIT];
  wire [31:0] bitpos = 32'h1 << cfg.img_bit;

  // ----------------------------------------
  // Memory arbitration
  // ----------------------------------------
  // Refresh takes priority.
  wire        ref_go  = tim.dot_en & ~tim.hblank & ~tim.vblank;
  wire        host_go = (st_q == DS_REQ) & ~ref_go & ~er_busy_q;
  wire        er_go   = er_busy_q & ~ref_go;
  wire [8:0]  row_lo  = {1'b0, tim.line[7:0] + scroll_act_q[7:0]};
  wire [8:0]  row_il  = {tim.line[7:0], tim.field} + scroll_act_q;
  wire [8:0]  row     = cfg.v512 ? row_il : row_lo;
  wire [17:0] ref_a   = dot_addr(cfg.fmt, tim.dot_idx[9:0], row);
  wire [17:0] host_a  = dot_addr(cfg.fmt, x_q, y_q);
  wire        mem_en  = ref_go | host_go | er_go;
  wire        mem_we  = ~ref_go & (er_go | (host_go & dp_wr_q));
  wire [17:0] mem_a   = ref_go ? ref_a : er_busy_q ? er_cnt_q : host_a;
  wire        mem_wd  = er_busy_q ? er_val_q : wr_bit;
  logic       mem_rd;

  bgdc_mem #(
    .AW      (18)
  ) u_mem (
    .clock   (clock),
    .en      (mem_en),
    .we      (mem_we),
    .addr    (mem_a),
    .wdata   (mem_wd),
    .rdata_q (mem_rd)
  );

  // ----------------------------------------
  // Dot access sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      DS_IDLE: begin
        if (acc_dt) begin
          st_d = DS_REQ;
        end
      end
      DS_REQ: begin
        if (host_go) begin
          st_d = DS_HOLD;
        end
      end
      DS_HOLD: begin
        if (wt_q == 2'h1) begin
          st_d = DS_DONE;
        end
      end
      DS_DONE: begin
        st_d = acc_dt ? DS_REQ : DS_IDLE;
      end
      default: begin
        st_d = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= DS_IDLE;
      wt_q <= 2'h0;
      hg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hg_q <= host_go;
      if (host_go) begin
        wt_q <= ram_wait(cfg.ram);
      end else if (st_q == DS_HOLD) begin
        wt_q <= wt_q - 2'h1;
      end
    end
  end

  assign hreadyout = ~(dp_dot & (st_q != DS_DONE));
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ----------------------------------------
  // Bus data phase and registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dp_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_hit_q <= 1'b0;
      dp_off_q <= 5'h00;
      hrdata_q <= 32'h0;
    end else begin
      if (hreadyout) begin
        dp_q <= acc;
        dp_wr_q <= hwrite;
        dp_hit_q <= hit;
        dp_off_q <= off;
      end
      if (acc && !hwrite) begin
        hrdata_q <= rd_reg;
      end else if (hg_q && !dp_wr_q) begin
        hrdata_q <= mem_rd ? bitpos : 32'h0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      x_q <= 10'h000;
      y_q <= 9'h000;
      scroll_q <= 9'h000;
      ctrl_q <= CTRL_RST;
    end else if (reg_wr) begin
      if (dp_off_q == REG_X) begin
        x_q <= hwdata[9:0];
      end else if (dp_off_q == REG_Y) begin
        y_q <= hwdata[8:0];
      end else if (dp_off_q == REG_SCROLL) begin
        scroll_q <= hwdata[8:0];
      end else if (dp_off_q == REG_CTRL) begin
        ctrl_q <= {31'h0, hwdata[CTRL_VIDEO]};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scroll_act_q <= 9'h000;
    end else if (tim.frame_end) begin
      scroll_act_q <= scroll_q;
    end
  end

  // ----------------------------------------
  // Memory erase
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      er_busy_q <= 1'b0;
      er_val_q <= 1'b0;
      er_cnt_q <= 18'h0;
    end else if (host_go && dp_wr_q && wr_era) begin
      er_busy_q <= 1'b1;
      er_val_q <= wr_bit;
      er_cnt_q <= 18'h0;
    end else if (er_go) begin
      er_cnt_q <= er_cnt_q + 18'h1;
      if (er_cnt_q == 18'h3ffff) begin
        er_busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Video output
  // ----------------------------------------
  // Merge alphanumeric video.
  wire vid = ((pix_q & ctrl_q[CTRL_VIDEO]) | alpha) & ~blank_d1_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rg_q <= 1'b0;
      pix_q <= 1'b0;
      blank_d1_q <= 1'b1;
      out_q <= 4'h2;
    end else begin
      rg_q <= ref_go;
      blank_d1_q <= tim.hblank | tim.vblank;
      if (rg_q) begin
        pix_q <= mem_rd;
      end
      out_q <= {tim.vsync, tim.hsync, blank_d1_q, vid};
    end
  end

  assign video_o = out_q[0];
  assign blank_o = out_q[1];
  assign hsync_o = out_q[2];
  assign vsync_o = out_q[3];

  // Same address, own bit.
  // Every board decodes the same base and takes only its strapped bit.

  // Dot write bounded.
  // A dot waits at most one refresh slot plus the RAM hold time, or until a running erase ends.

endmodule

/* File: tb.sv */
// Self-checking bench of the bitmap display block.
// Assumes the block is strapped as sync master with shortened line counts.
`timescale 1ns/1ps
module tb;
  import bgdc_pkg::*;
  logic         clock, rst, alpha_i, hsel, hwrite, hreadyout, hresp, rd_pend, v, pd;
  logic         dot_o, dot_oe, hres_o, hres_oe, vres_o, vres_oe;
  logic         video_o, blank_o, hsync_o, vsync_o;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata, base_a, x, y, d;
  logic [31:0]  exp_q[$];
  logic [31:0]  msk_q[$];
  bgdc_straps_s straps;
  int           mismatches, n_compared, last_n, hits, dots, dv;
  wire logic dot_w  = dot_oe ? dot_o : 1'b0;
  wire logic hres_w = hres_oe ? hres_o : 1'b0;
  wire logic vres_w = vres_oe ? vres_o : 1'b0;
  always #5 clock = ~clock;
  bgdc_top #(.LINE_CYC(200), .ACT_CYC(100), .HS_CYC(20), .VS_CYC(30)) bgdc_top_i (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .straps(straps),
    .dot_i(dot_w), .dot_o(dot_o), .dot_oe(dot_oe), .hres_i(hres_w), .hres_o(hres_o),
    .hres_oe(hres_oe), .vres_i(vres_w), .vres_o(vres_o), .vres_oe(vres_oe),
    .alpha_i(alpha_i), .video_o(video_o), .blank_o(blank_o), .hsync_o(hsync_o),
    .vsync_o(vsync_o));
  bgdc_host bgdc_host_i (.clock(clock), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  function automatic logic [31:0] ra(input logic [4:0] o);
    return base_a | {27'h0, o};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dw);
    logic [31:0] r;
    bgdc_host_i.xfer(1'b1, a, dw, r, last_n);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    exp_q.push_back(e);
    msk_q.push_back(m);
    bgdc_host_i.xfer(1'b0, a, 32'h0, r, last_n);
  endtask
  // -------------------------------
  // Read result monitor
  // -------------------------------
  always @(posedge clock) begin
    if (rd_pend && hreadyout === 1'b1) begin
      check(hrdata & msk_q.pop_front(), exp_q.pop_front());
      rd_pend = 1'b0;
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_pend = 1'b1;
  end
  initial begin
    #800000;
    mismatches++;
    conclude();
  end
  // -------------------------------
  // Main sequence
  // -------------------------------
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    alpha_i = 1'b0;
    rd_pend = 1'b0;
    mismatches = 0;
    n_compared = 0;
    hits = 0;
    void'($urandom(91));
    straps = bgdc_straps_s'(22'($urandom));
    straps.master = 1'b1;
    straps.pal = 1'b0;
    base_a = {BASE_HI_DF, straps.base, 5'h00};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    rd(ra(REG_CTRL), CTRL_RST, 32'hffff_ffff);
    rd(ra(REG_CTRL) ^ 32'h100, 32'h0, 32'hffff_ffff);
    wr(ra(REG_SCROLL), 32'h0000_01a5);
    rd(ra(REG_SCROLL), 32'h0000_01a5, 32'hffff_ffff);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      x = $urandom_range(1023, 0);
      y = $urandom_range(511, 0);
      v = 1'($urandom);
      d = ($urandom & 32'h0000_ffff & ~(32'h1 << straps.img_bit)) | (32'(v) << straps.img_bit);
      wr(ra(REG_X), x);
      wr(ra(REG_Y), y);
      wr(ra(REG_DATA), d);
      check(32'(last_n <= 140), 32'h1);
      rd(ra(REG_DATA), 32'(v) << straps.img_bit, 32'hffff_ffff);
    end
    $display("test dots done");
    alpha_i <= 1'b1;
    dots = 0;
    dv = int'(straps.fast_dot ? DIV_FAST : DIV_SLOW);
    pd = dot_o;
    repeat (400) begin
      @(posedge clock);
      hits += int'(video_o === 1'b1);
      dots += int'(dot_o === 1'b1 && pd === 1'b0);
      pd = dot_o;
    end
    alpha_i <= 1'b0;
    check(32'(hits > 0), 32'h1);
    check(32'(dots == 400 / dv || dots == 400 / dv + 1), 32'h1);
    check({29'h0, dot_oe, hres_oe, vres_oe}, 32'h7);
    $display("test alpha done");
    for (int t = 0; t < 60000 && vsync_o !== 1'b1; t++) @(posedge clock);
    check({31'h0, vsync_o}, 32'h1);
    for (int t = 0; t < 8000 && vres_o !== 1'b1; t++) @(posedge clock);
    check({31'h0, vres_o}, 32'h1);
    @(posedge clock);
    check({31'h0, vres_o}, 32'h0);
    $display("test frame done");
    wr(ra(REG_DATA), (32'h1 << ERASE_BIT) | (32'h1 << straps.img_bit));
    rd(ra(REG_STAT), 32'ha, 32'ha);
    $display("test erase done");
    repeat (2) @(posedge clock);
    conclude();
  end
endmodule
